// File: common/apdc_pkg.sv
// Purpose: Shared types and constants for amplitude/phase detect compare
// Assumes: AXI4-Lite, 32-bit data, 8-bit byte address
// Notes:   Register index times four gives the byte address
`default_nettype none
package apdc_pkg;
    // ************************************************************
    // Bus carriers
    // ************************************************************
    typedef struct packed {
        logic [7:0]  awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [7:0]  araddr;
        logic        arvalid;
        logic        rready;
    } apdc_axil_req_type;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } apdc_axil_rsp_type;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } apdc_meas_type;

    // ************************************************************
    // Register indices and byte addresses
    // ************************************************************
    localparam logic [7:0] APDC_IDX_AMP_CFG   = 8'h32;
    localparam logic [7:0] APDC_IDX_AMP_REF   = 8'h33;
    localparam logic [7:0] APDC_IDX_AMP_AVG   = 8'h34;
    localparam logic [7:0] APDC_IDX_AMP_LAST  = 8'h35;
    localparam logic [7:0] APDC_IDX_PHS_CFG   = 8'h36;
    localparam logic [7:0] APDC_IDX_PHS_REF   = 8'h37;
    localparam logic [7:0] APDC_IDX_PHS_AVG   = 8'h38;
    localparam logic [7:0] APDC_IDX_PHS_LAST  = 8'h39;
    localparam logic [7:0] APDC_ADDR_AMP_CFG  = {APDC_IDX_AMP_CFG[5:0], 2'h0};
    localparam logic [7:0] APDC_ADDR_AMP_REF  = {APDC_IDX_AMP_REF[5:0], 2'h0};
    localparam logic [7:0] APDC_ADDR_AMP_AVG  = {APDC_IDX_AMP_AVG[5:0], 2'h0};
    localparam logic [7:0] APDC_ADDR_AMP_LAST = {APDC_IDX_AMP_LAST[5:0], 2'h0};
    localparam logic [7:0] APDC_ADDR_PHS_CFG  = {APDC_IDX_PHS_CFG[5:0], 2'h0};
    localparam logic [7:0] APDC_ADDR_PHS_REF  = {APDC_IDX_PHS_REF[5:0], 2'h0};
    localparam logic [7:0] APDC_ADDR_PHS_AVG  = {APDC_IDX_PHS_AVG[5:0], 2'h0};
    localparam logic [7:0] APDC_ADDR_PHS_LAST = {APDC_IDX_PHS_LAST[5:0], 2'h0};
    localparam logic [7:0] APDC_ADDR_CTRL     = 8'hF0;
    localparam logic [7:0] APDC_ADDR_STATUS   = 8'hF4;
    localparam logic [7:0] APDC_ADDR_MASK     = 8'hF8;

    // ************************************************************
    // Fields and reset values
    // ************************************************************
    localparam int         APDC_THR_MSB       = 7;
    localparam int         APDC_THR_LSB       = 4;
    localparam int         APDC_INCL_BIT      = 3;
    localparam int         APDC_WGT_MSB       = 2;
    localparam int         APDC_WGT_LSB       = 1;
    localparam int         APDC_USEAVG_BIT    = 0;
    localparam logic [2:0] APDC_WGT_SHIFT_BASE = 3'h2;
    localparam int         APDC_CTRL_DEF_BIT  = 7;
    localparam logic [7:0] APDC_CFG_RST       = 8'h00;
    localparam logic [7:0] APDC_REF_RST       = 8'h00;
    localparam int         APDC_CH_AMP        = 0;
    localparam int         APDC_CH_PHS        = 1;
    localparam int         APDC_ST_DONE_BASE  = 2;
    localparam logic [1:0] APDC_RESP_OKAY     = 2'h0;
    localparam logic [1:0] APDC_RESP_SLVERR   = 2'h2;
endpackage
`default_nettype wire

// File: hw/apdc_axil.sv
// Purpose: AXI4-Lite slave front end for the detect compare registers
// Assumes: One write and one read in flight; register decode is combinational
// Notes:   Write answers two edges after both beats; read one edge after AR
`default_nettype none
module apdc_axil (
    // Clock and control
    input  wire logic                        clk_sys_in,
    input  wire logic                        srst_in,
    input  wire logic                        ce_in,
    // Bus
    input  wire apdc_pkg::apdc_axil_req_type axi_req_in,
    output apdc_pkg::apdc_axil_rsp_type      axi_rsp_out,
    // Register side
    output logic                             wr_en_out,
    output logic [7:0]                       wr_addr_out,
    output logic [31:0]                      wr_data_out,
    output logic [3:0]                       wr_strb_out,
    input  wire logic                        wr_ok_in,
    output logic                             rd_en_out,
    output logic [7:0]                       rd_addr_out,
    input  wire logic [31:0]                 rd_data_in,
    input  wire logic                        rd_ok_in
);
    import apdc_pkg::*;

    typedef struct packed {
        logic [7:0]        awaddr;
        logic              aw_got;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              w_got;
        apdc_axil_rsp_type rsp;
    } apdc_axil_state_type;

    apdc_axil_state_type s_reg;
    apdc_axil_state_type s_next;
    logic                wr_fire;
    logic                rd_fire;

    always_comb
    begin
        s_next  = s_reg;
        wr_fire = 1'b0;
        rd_fire = 1'b0;
        if (s_reg.rsp.awready && axi_req_in.awvalid)
        begin
            s_next.awaddr = axi_req_in.awaddr;
            s_next.aw_got = 1'b1;
        end
        if (s_reg.rsp.wready && axi_req_in.wvalid)
        begin
            s_next.wdata = axi_req_in.wdata;
            s_next.wstrb = axi_req_in.wstrb;
            s_next.w_got = 1'b1;
        end
        if (s_reg.rsp.bvalid && axi_req_in.bready)
            s_next.rsp.bvalid = 1'b0;
        // Both beats held: commit and answer
        if (s_reg.aw_got && s_reg.w_got && !s_reg.rsp.bvalid)
        begin
            wr_fire           = ce_in;
            s_next.aw_got     = 1'b0;
            s_next.w_got      = 1'b0;
            s_next.rsp.bvalid = 1'b1;
            s_next.rsp.bresp  = wr_ok_in ? APDC_RESP_OKAY : APDC_RESP_SLVERR;
        end
        if (s_reg.rsp.rvalid && axi_req_in.rready)
            s_next.rsp.rvalid = 1'b0;
        if (s_reg.rsp.arready && axi_req_in.arvalid)
        begin
            rd_fire           = ce_in;
            s_next.rsp.rvalid = 1'b1;
            s_next.rsp.rdata  = rd_data_in;
            s_next.rsp.rresp  = rd_ok_in ? APDC_RESP_OKAY : APDC_RESP_SLVERR;
        end
        // Ready only while the slot is free, so one transfer per direction
        s_next.rsp.awready = !s_next.aw_got && !s_next.rsp.bvalid;
        s_next.rsp.wready  = !s_next.w_got && !s_next.rsp.bvalid;
        s_next.rsp.arready = !s_next.rsp.rvalid;
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
            s_reg <= '0;
        else if (ce_in)
            s_reg <= s_next;
    end

    assign axi_rsp_out = s_reg.rsp;
    assign wr_en_out   = wr_fire;
    assign wr_addr_out = s_reg.awaddr;
    assign wr_data_out = s_reg.wdata;
    assign wr_strb_out = s_reg.wstrb;
    assign rd_en_out   = rd_fire;
    assign rd_addr_out = axi_req_in.araddr;
endmodule
`default_nettype wire

// File: hw/apdc_chan.sv
// Purpose: One channel: threshold compare and running average
// Assumes: Result valid is a single-cycle strobe on the system clock
// Notes:   Average uses an arithmetic shift, so negative steps round down
`default_nettype none
module apdc_chan (
    // Clock and control
    input  wire logic       clk_sys_in,
    input  wire logic       srst_in,
    input  wire logic       ce_in,
    input  wire logic       clear_in,
    // Configuration
    input  wire logic [7:0] cfg_in,
    input  wire logic [7:0] stored_ref_in,
    // Measurement
    input  wire logic       res_valid_in,
    input  wire logic [7:0] res_data_in,
    // Results
    output logic [7:0]      avg_out,
    output logic [7:0]      last_out,
    output logic            trig_out,
    output logic            done_out
);
    import apdc_pkg::*;

    typedef struct packed {
        logic [7:0] avg;
        logic [7:0] last;
        logic       trig;
        logic       done;
    } apdc_chan_state_type;

    apdc_chan_state_type s_reg;
    apdc_chan_state_type s_next;
    logic [7:0]          ref_sel;
    logic [7:0]          mag;
    logic                over;
    logic signed [8:0]   step;
    logic signed [8:0]   shifted;

    always_comb
    begin
        ref_sel = cfg_in[APDC_USEAVG_BIT] ? s_reg.avg : stored_ref_in;
        mag     = (res_data_in >= ref_sel) ? res_data_in - ref_sel
                                           : ref_sel - res_data_in;
        over    = mag > {4'h0, cfg_in[APDC_THR_MSB:APDC_THR_LSB]};
        step    = $signed({1'b0, res_data_in}) - $signed({1'b0, s_reg.avg});
        shifted = step >>> (APDC_WGT_SHIFT_BASE
                  + {1'b0, cfg_in[APDC_WGT_MSB:APDC_WGT_LSB]});
        s_next      = s_reg;
        s_next.trig = 1'b0;
        s_next.done = 1'b0;
        if (clear_in)
            s_next = '0;
        else if (res_valid_in)
        begin
            s_next.last = res_data_in;
            s_next.done = 1'b1;
            s_next.trig = over;
            if (!over || cfg_in[APDC_INCL_BIT])
                s_next.avg = s_reg.avg + shifted[7:0];
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
            s_reg <= '0;
        else if (ce_in)
            s_reg <= s_next;
    end

    assign avg_out  = s_reg.avg;
    assign last_out = s_reg.last;
    assign trig_out = s_reg.trig;
    assign done_out = s_reg.done;

    // ************************************************************
    // Checks
    // ************************************************************
    logic take;
    assign take = res_valid_in && ce_in && !clear_in;

    a_trig_vs_thresh: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        take |=> trig_out == $past(over))
        else $error("trigger does not follow threshold compare");
    a_excl_hold_avg: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        take && over && !cfg_in[APDC_INCL_BIT] |=> avg_out == $past(avg_out))
        else $error("excluded trigger result moved the average");
    a_weight_four: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        take && cfg_in[2:1] == 2'h0 && avg_out < 8'hF0 && res_data_in == avg_out + 8'h04
        && (!over || cfg_in[APDC_INCL_BIT]) |=> avg_out == $past(avg_out) + 8'h01)
        else $error("weight four step wrong");
    a_ref_stored_eq: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        take && !cfg_in[APDC_USEAVG_BIT] && res_data_in == stored_ref_in |=> !trig_out)
        else $error("equal to stored reference still triggered");
    a_last_capture: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        take |=> last_out == $past(res_data_in) && done_out)
        else $error("last result not captured");
    c_avg_ref_trig: cover property (@(posedge clk_sys_in) disable iff (srst_in)
        take && cfg_in[APDC_USEAVG_BIT] && over);
endmodule
`default_nettype wire

// File: hw/apdc_core.sv
// Purpose: Amplitude and phase card-presence compare with register file
// Assumes: Wake and measurement strobes come from logic on clk_sys_in
// Notes:   Printed register numbers are indices; byte address is four times
//
// Added by the designer: the AXI4-Lite slave port.
`default_nettype none
module apdc_core (
    // Clock and control
    input  wire logic                        clk_sys_in,
    input  wire logic                        srst_in,
    input  wire logic                        ce_in,
    // Register bus
    input  wire apdc_pkg::apdc_axil_req_type axi_req_in,
    output apdc_pkg::apdc_axil_rsp_type      axi_rsp_out,
    // Wake-up timer and measurement path
    input  wire logic                        wake_in,
    input  wire apdc_pkg::apdc_meas_type [1:0] meas_in,
    output logic [1:0]                       meas_req_out,
    // Interrupt
    output logic                             irq_out
);
    import apdc_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [1:0][7:0] cfg;
        logic [1:0][7:0] sref;
        logic [1:0]      en;
        logic [3:0]      status;
        logic [3:0]      mask;
        logic [1:0]      req;
        logic [1:0]      pending;
        logic            irq;
    } apdc_core_state_type;

    apdc_core_state_type s_reg;
    apdc_core_state_type s_next;

    logic             wr_en;
    logic [7:0]       wr_addr;
    logic [31:0]      wr_data;
    logic [3:0]       wr_strb;
    logic             wr_ok;
    logic [7:0]       rd_addr;
    logic [31:0]      rd_data;
    logic             rd_ok;
    logic             wr_lane;
    logic [7:0]       wr_byte;
    logic             defaults_cmd;
    logic [3:0]       w1c;
    logic [3:0]       events;
    logic [1:0]       accept;
    logic [1:0][7:0]  avg;
    logic [1:0][7:0]  last;
    logic [1:0]       trig;
    logic [1:0]       done;

    // ************************************************************
    // Bus slave
    // ************************************************************
    apdc_axil i_apdc_axil (
        .clk_sys_in  (clk_sys_in),
        .srst_in     (srst_in),
        .ce_in       (ce_in),
        .axi_req_in  (axi_req_in),
        .axi_rsp_out (axi_rsp_out),
        .wr_en_out   (wr_en),
        .wr_addr_out (wr_addr),
        .wr_data_out (wr_data),
        .wr_strb_out (wr_strb),
        .wr_ok_in    (wr_ok),
        .rd_en_out   (),
        .rd_addr_out (rd_addr),
        .rd_data_in  (rd_data),
        .rd_ok_in    (rd_ok)
    );

    // ************************************************************
    // Channels
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_chan
            // Results arriving with no request outstanding are dropped
            assign accept[gi] = meas_in[gi].valid && s_reg.pending[gi];
            apdc_chan i_apdc_chan (
                .clk_sys_in    (clk_sys_in),
                .srst_in       (srst_in),
                .ce_in         (ce_in),
                .clear_in      (defaults_cmd),
                .cfg_in        (s_reg.cfg[gi]),
                .stored_ref_in (s_reg.sref[gi]),
                .res_valid_in  (accept[gi]),
                .res_data_in   (meas_in[gi].data),
                .avg_out       (avg[gi]),
                .last_out      (last[gi]),
                .trig_out      (trig[gi]),
                .done_out      (done[gi])
            );
        end
    endgenerate

    // ************************************************************
    // Register decode
    // ************************************************************
    function automatic logic mapped(input logic [7:0] a);
        logic hit;
        hit = 1'b0;
        case (a)
            APDC_ADDR_AMP_CFG, APDC_ADDR_AMP_REF, APDC_ADDR_AMP_AVG,
            APDC_ADDR_AMP_LAST, APDC_ADDR_PHS_CFG, APDC_ADDR_PHS_REF,
            APDC_ADDR_PHS_AVG, APDC_ADDR_PHS_LAST, APDC_ADDR_CTRL,
            APDC_ADDR_STATUS, APDC_ADDR_MASK:
                hit = 1'b1;
            default:
                hit = 1'b0;
        endcase
        return hit;
    endfunction

    assign wr_ok        = mapped(wr_addr);
    assign rd_ok        = mapped(rd_addr);
    assign wr_lane      = wr_en && wr_strb[0];
    assign wr_byte      = wr_data[7:0];
    assign defaults_cmd = wr_lane && wr_addr == APDC_ADDR_CTRL
                          && wr_byte[APDC_CTRL_DEF_BIT];
    assign w1c          = (wr_lane && wr_addr == APDC_ADDR_STATUS) ? wr_byte[3:0] : 4'h0;
    assign events       = {done, trig};

    always_comb
    begin
        rd_data = 32'h0000_0000;
        case (rd_addr)
            APDC_ADDR_AMP_CFG:  rd_data[7:0] = s_reg.cfg[APDC_CH_AMP];
            APDC_ADDR_AMP_REF:  rd_data[7:0] = s_reg.sref[APDC_CH_AMP];
            APDC_ADDR_AMP_AVG:  rd_data[7:0] = avg[APDC_CH_AMP];
            APDC_ADDR_AMP_LAST: rd_data[7:0] = last[APDC_CH_AMP];
            APDC_ADDR_PHS_CFG:  rd_data[7:0] = s_reg.cfg[APDC_CH_PHS];
            APDC_ADDR_PHS_REF:  rd_data[7:0] = s_reg.sref[APDC_CH_PHS];
            APDC_ADDR_PHS_AVG:  rd_data[7:0] = avg[APDC_CH_PHS];
            APDC_ADDR_PHS_LAST: rd_data[7:0] = last[APDC_CH_PHS];
            APDC_ADDR_CTRL:     rd_data[1:0] = s_reg.en;
            APDC_ADDR_STATUS:   rd_data[3:0] = s_reg.status;
            APDC_ADDR_MASK:     rd_data[3:0] = s_reg.mask;
            default:            rd_data = 32'h0000_0000;
        endcase
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        s_next = s_reg;
        if (defaults_cmd)
        begin
            s_next.cfg     = {APDC_CFG_RST, APDC_CFG_RST};
            s_next.sref    = {APDC_REF_RST, APDC_REF_RST};
            s_next.en      = 2'h0;
            s_next.pending = 2'h0;
        end
        else if (wr_lane)
        begin
            case (wr_addr)
                APDC_ADDR_AMP_CFG: s_next.cfg[APDC_CH_AMP]  = wr_byte;
                APDC_ADDR_AMP_REF: s_next.sref[APDC_CH_AMP] = wr_byte;
                APDC_ADDR_PHS_CFG: s_next.cfg[APDC_CH_PHS]  = wr_byte;
                APDC_ADDR_PHS_REF: s_next.sref[APDC_CH_PHS] = wr_byte;
                APDC_ADDR_CTRL:    s_next.en   = wr_byte[1:0];
                APDC_ADDR_MASK:    s_next.mask = wr_byte[3:0];
                default:           s_next.mask = s_reg.mask;
            endcase
        end
        // Hardware events win over a clear in the same cycle
        s_next.status = (s_reg.status & ~w1c) | events;
        // Expiry starts one measurement per enabled channel
        s_next.req = (wake_in && !defaults_cmd) ? s_reg.en : 2'h0;
        if (!defaults_cmd)
            s_next.pending = (s_reg.pending & ~accept) | s_next.req;
        s_next.irq = |(s_next.status & s_next.mask);
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
            s_reg <= '0;
        else if (ce_in)
            s_reg <= s_next;
    end

    assign meas_req_out = s_reg.req;
    assign irq_out      = s_reg.irq;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (srst_in);

    logic wr_plain;
    assign wr_plain = ce_in && wr_lane && !defaults_cmd;

    a_amp_cfg_write: assert property (
        wr_plain && wr_addr == APDC_ADDR_AMP_CFG
        |=> s_reg.cfg[APDC_CH_AMP] == $past(wr_byte) && $stable(s_reg.cfg[APDC_CH_PHS]))
        else $error("amplitude config write wrong");
    a_phs_cfg_write: assert property (
        wr_plain && wr_addr == APDC_ADDR_PHS_CFG
        |=> s_reg.cfg[APDC_CH_PHS] == $past(wr_byte) && $stable(s_reg.cfg[APDC_CH_AMP]))
        else $error("phase config write wrong");
    a_ref_write: assert property (
        wr_plain && wr_addr == APDC_ADDR_AMP_REF |=> s_reg.sref[APDC_CH_AMP] == $past(wr_byte))
        else $error("amplitude reference write lost");
    a_defaults_clear: assert property (
        ce_in && defaults_cmd
        |=> s_reg.cfg == 16'h0000 && s_reg.sref == 16'h0000
        && avg == 16'h0000 && last == 16'h0000)
        else $error("restore defaults left state behind");
    a_wake_request: assert property (
        ce_in && wake_in && !defaults_cmd && s_reg.en[APDC_CH_AMP]
        |=> meas_req_out[APDC_CH_AMP] && s_reg.pending[APDC_CH_AMP])
        else $error("enabled wake did not request amplitude");
    a_trig_to_irq: assert property (
        ce_in && trig[APDC_CH_PHS] && s_reg.mask[APDC_CH_PHS] |=> irq_out)
        else $error("unmasked phase trigger gave no interrupt");
    a_irq_level: assert property (
        irq_out == |(s_reg.status & s_reg.mask))
        else $error("interrupt does not match status and mask");

    c_amp_trigger: cover property (meas_req_out[APDC_CH_AMP] ##[1:20] trig[APDC_CH_AMP]);
    c_irq_raised:  cover property (!irq_out ##1 irq_out);
    c_defaults:    cover property (defaults_cmd);
endmodule
`default_nettype wire

// File: verif/apdc_core_tb.sv
// Purpose: Self-checking bench for the amplitude/phase detect compare block
// Assumes: Clock enable high except in the freeze scenario; expectations worked by hand
// Notes:   Each scenario task drives the block and judges the answers
`default_nettype none
module apdc_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import apdc_pkg::*;
    logic                    clk_sys_in;
    logic                    srst_in;
    logic                    wake;
    logic                    ce;
    logic                    irq;
    logic [1:0]              mreq;
    apdc_axil_req_type       req;
    apdc_axil_rsp_type       rsp;
    apdc_meas_type [1:0]     meas;
    int                      miscompares = 0;
    int                      comparisons = 0;
    apdc_core i_apdc_core (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .ce_in(ce),
        .axi_req_in(req), .axi_rsp_out(rsp), .wake_in(wake), .meas_in(meas),
        .meas_req_out(mreq), .irq_out(irq));
    initial
    begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end
    // ********
    // Bus and check tasks
    // ********
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e)
        begin
            miscompares++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk_sys_in);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do
        begin
            @(posedge clk_sys_in);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1);
        req.bready <= 1'b0;
        chk("bresp", 32'(rsp.bresp), 32'(r));
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys_in);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do
        begin
            @(posedge clk_sys_in);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1);
        req.rready <= 1'b0;
        chk("rresp", 32'(rsp.rresp), 32'(APDC_RESP_OKAY));
        chk("rdata", rsp.rdata, 32'(e));
    endtask
    task automatic ms(input int c, input logic [7:0] d);
        @(posedge clk_sys_in);
        wake <= 1'b1;
        @(posedge clk_sys_in);
        wake <= 1'b0;
        @(posedge clk_sys_in);
        chk("meas_req", 32'(mreq[c]), 32'h1);
        meas[c].valid <= 1'b1;
        meas[c].data <= d;
        @(posedge clk_sys_in);
        meas[c].valid <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
    endtask
    task automatic end_sim;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ********
    // Scenarios
    // ********
    task automatic t_regs;
        for (int i = 0; i < 8; i++) rd(APDC_ADDR_AMP_CFG + 8'(4 * i), 8'h00);
        wr(APDC_ADDR_AMP_CFG, 32'hF8, APDC_RESP_OKAY);
        wr(APDC_ADDR_AMP_REF, 32'h30, APDC_RESP_OKAY);
        wr(APDC_ADDR_PHS_CFG, 32'hF4, APDC_RESP_OKAY);
        wr(APDC_ADDR_PHS_REF, 32'h28, APDC_RESP_OKAY);
        wr(APDC_ADDR_AMP_AVG, 32'h55, APDC_RESP_OKAY);
        wr(8'h00, 32'h01, APDC_RESP_SLVERR);
        rd(APDC_ADDR_AMP_CFG, 8'hF8);
        rd(APDC_ADDR_PHS_REF, 8'h28);
        rd(APDC_ADDR_AMP_AVG, 8'h00);
    endtask
    task automatic t_amp;
        wr(APDC_ADDR_CTRL, 32'h03, APDC_RESP_OKAY);
        wr(APDC_ADDR_MASK, 32'h01, APDC_RESP_OKAY);
        ms(0, 8'h40);
        rd(APDC_ADDR_AMP_LAST, 8'h40);
        rd(APDC_ADDR_AMP_AVG, 8'h10);
        rd(APDC_ADDR_STATUS, 8'h05);
        chk("irq", 32'(irq), 32'h1);
        wr(APDC_ADDR_STATUS, 32'h05, APDC_RESP_OKAY);
        wr(APDC_ADDR_AMP_CFG, 32'hF9, APDC_RESP_OKAY);
        chk("irq", 32'(irq), 32'h0);
        // Within threshold of the average but far from the stored reference
        ms(0, 8'h18);
        rd(APDC_ADDR_STATUS, 8'h04);
        rd(APDC_ADDR_AMP_AVG, 8'h12);
    endtask
    task automatic t_phs;
        ms(1, 8'h20);
        rd(APDC_ADDR_PHS_AVG, 8'h02);
        ms(1, 8'h50);
        rd(APDC_ADDR_PHS_AVG, 8'h02);
        rd(APDC_ADDR_PHS_LAST, 8'h50);
        rd(APDC_ADDR_STATUS, 8'h0E);
        chk("irq", 32'(irq), 32'h0);
        wr(APDC_ADDR_CTRL, 32'h80, APDC_RESP_OKAY);
        for (int i = 0; i < 8; i++) rd(APDC_ADDR_AMP_CFG + 8'(4 * i), 8'h00);
    endtask
    task automatic t_ce;
        wr(APDC_ADDR_CTRL, 32'h01, APDC_RESP_OKAY);
        wr(APDC_ADDR_AMP_CFG, 32'hF0, APDC_RESP_OKAY);
        // Enable low: the wake pulse must leave no request and nothing pending
        ce <= 1'b0;
        wake <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        chk("meas_req", 32'(mreq), 32'h0);
        wake <= 1'b0;
        ce <= 1'b1;
        meas[0].valid <= 1'b1;
        meas[0].data <= 8'h07;
        @(posedge clk_sys_in);
        meas[0].valid <= 1'b0;
        rd(APDC_ADDR_AMP_LAST, 8'h00);
        ms(0, 8'h04);
        rd(APDC_ADDR_AMP_AVG, 8'h01);
        rd(APDC_ADDR_AMP_LAST, 8'h04);
    endtask
    initial
    begin
        req = '0;
        meas = '0;
        wake = 1'b0;
        ce = 1'b1;
        srst_in = 1'b1;
        repeat (5) @(posedge clk_sys_in);
        srst_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        t_regs();
        t_amp();
        t_phs();
        t_ce();
        end_sim();
    end
    initial
    begin
        repeat (5000) @(posedge clk_sys_in);
        miscompares++;
        end_sim();
    end
endmodule
`default_nettype wire
